/* File: design/monitor_regs_pkg.sv */
// Register map, field positions, reset values and result formats of the monitor register bank.
package monitor_regs_pkg;

   localparam logic [4:0] ADDR_STATUS_LOW     = 5'h00;
   localparam logic [4:0] ADDR_STATUS_HIGH    = 5'h01;
   localparam logic [4:0] ADDR_CTRL_PAIR_LOW  = 5'h06;
   localparam logic [4:0] ADDR_CTRL_PAIR_HIGH = 5'h07;
   localparam logic [4:0] ADDR_DUTY_CTRL      = 5'h08;
   localparam logic [4:0] ADDR_DUTY_THRESHOLD = 5'h09;
   localparam logic [4:0] ADDR_RESULT_FIRST   = 5'h0a;
   localparam logic [4:0] ADDR_AMBIENT_HIGH   = 5'h1a;
   localparam logic [4:0] ADDR_AMBIENT_LOW    = 5'h1b;
   localparam logic [4:0] ADDR_SUPPLY_HIGH    = 5'h1c;
   localparam logic [4:0] ADDR_SUPPLY_LOW     = 5'h1d;
   localparam logic [4:0] ADDR_RESULT_LAST    = 5'h1d;

   localparam int         RESULT_PAIRS  = 10;
   localparam logic [3:0] PAIR_AMBIENT  = 4'h8;
   localparam logic [3:0] PAIR_SUPPLY   = 4'h9;
   localparam logic [3:0] PAIR_LIMIT    = 4'ha;

   localparam int FRESH_BIT          = 7;
   localparam int SIGN_BIT           = 6;
   localparam int DUTY_LSB_BIT       = 7;
   localparam int DUTY_INVERT_BIT    = 6;
   localparam int DUTY_ENABLE_BIT    = 5;
   localparam int REPEAT_BIT         = 4;
   localparam int BUSY_BIT           = 2;
   localparam int AMBIENT_FRESH_BIT  = 1;
   localparam int SUPPLY_FRESH_BIT   = 0;

   localparam logic [7:0] REG_RESET          = 8'h00;
   localparam logic [7:0] DUTY_CTRL_MASK     = 8'hfc;
   localparam logic [7:0] STATUS_HIGH_MASK   = 8'hf8;

   localparam int DUTY_WIDTH = 9;

   localparam real SINGLE_ENDED_LSB_UV = 305.18;
   localparam real DIFFERENTIAL_LSB_UV = 19.075;
   localparam real SUPPLY_OFFSET_V     = 2.5;
   localparam real TEMPERATURE_LSB_C   = 0.0625;
   localparam real DIODE_LSB_UV        = 38.15;

   typedef enum logic [2:0]
   {
      KIND_VOLTAGE     = 3'b001,
      KIND_TEMPERATURE = 3'b010,
      KIND_DIODE       = 3'b100
   } result_kind_t;

endpackage

/* File: design/duty_output_gen.sv */
// Duty-cycle output generator driven by the 9-bit duty threshold.
`timescale 1ns/1ps
`default_nettype none
module duty_output_gen
   import monitor_regs_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic [DUTY_WIDTH-1:0] threshold,
   input  wire logic                  enable,
   input  wire logic                  invert,
   output logic                       duty_out
);

   logic [DUTY_WIDTH-1:0] phase;
   logic                  next_duty;

   // A free-running phase keeps the period fixed at 512 cycles whatever the threshold.
   assign next_duty = enable ? ((phase < threshold) ^ invert) : invert;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         phase    <= '0;
         duty_out <= 1'b0;
      end
      else if (ce)
      begin
         phase    <= phase + 9'h001;
         duty_out <= next_duty;
      end
   end

   property p_disabled_low;
      @(posedge mclk) disable iff (rst)
      (ce && !enable && !invert) |=> !duty_out;
   endproperty
   a_disabled_low: assert property (p_disabled_low) else $error("Disabled noninverted duty output not low.");

   property p_disabled_high;
      @(posedge mclk) disable iff (rst)
      (ce && !enable && invert) |=> duty_out;
   endproperty
   a_disabled_high: assert property (p_disabled_high) else $error("Disabled inverted duty output not high.");

endmodule
`default_nettype wire

/* File: design/monitor_result_registers.sv */
// Register bank of the monitor: control, duty threshold and conversion result registers.
// How it works
// - Duty threshold upper register comes out of reset as zero.
// - Nine-bit threshold: bits 8..1 in threshold register, bit 0 in control bit 7.
// - Duty output disabled and not inverted holds the pin low.
// - Duty output disabled and inverted holds the pin high.
// - A new result written into a pair sets its fresh flag.
// - Reading a result high byte clears its fresh flag.
// - Voltage high byte: fresh flag, sign, then result bits 13..8.
// - Voltage low byte holds result bits 7..0.
// - Temperature high byte: fresh flag, two unused zeros, result bits 12..8.
// - Temperature low byte holds result bits 7..0.
// - Diode high byte: fresh flag, two unused zeros, result bits 12..8.
// - Diode low byte holds result bits 7..0.
// - Single-ended voltage code is signed, one step is 2.5 V over 2^13.
// - Differential voltage step is 2.5 V over 2^17.
// - Supply result is supply minus 2.5 V at single-ended step.
// - Temperatures step one sixteenth degree; ambient result sits at 1A and 1B.
// - Diode voltages are 13-bit codes of about 38.15 uV per step.
// - Supply result sits at 1C high byte and 1D low byte.
// - Control bit 6 inverts the duty output, bit 5 enables it, both reset zero.
// - Power-on reset clears every register to zero.
`timescale 1ns/1ps
`default_nettype none
module monitor_result_registers
   import monitor_regs_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [7:0]   reg_addr,
   input  wire logic         reg_wr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_rd,
   output logic [7:0]        reg_rdata,
   output logic              reg_rvalid,
   input  wire logic         result_we,
   input  wire logic [3:0]   result_pair,
   input  wire result_kind_t result_kind,
   input  wire logic         result_sign,
   input  wire logic [13:0]  result_code,
   input  wire logic         conv_busy,
   output logic [4:0]        channel_enable,
   output logic [7:0]        chan_ctrl_low,
   output logic [7:0]        chan_ctrl_high,
   output logic              repeat_mode,
   output logic              duty_out
);

   logic [7:0]              duty_threshold_upper;
   logic [7:0]              duty_ctrl;
   logic [7:0]              status_high_ctrl;
   logic [6:0]              res_hi [RESULT_PAIRS];
   logic [7:0]              res_lo [RESULT_PAIRS];
   logic [RESULT_PAIRS-1:0] fresh;
   logic [7:0]              read_value;

   wire  [4:0]              addr = reg_addr[4:0];

   // Upper address bits are ignored, so every access folds onto the 32-entry map.
   function automatic logic is_result_addr(input logic [4:0] a);
      is_result_addr = (a >= ADDR_RESULT_FIRST) && (a <= ADDR_RESULT_LAST);
   endfunction

   function automatic logic [3:0] pair_of(input logic [4:0] a);
      logic [4:0] d;
      d = a - ADDR_RESULT_FIRST;
      pair_of = d[4:1];
   endfunction

   // The converter delivers codes already scaled and in two's complement; the bank only places bits.
   function automatic logic [6:0] format_high(input result_kind_t k, input logic s, input logic [13:0] c);
      logic [6:0] v;
      v = 7'h00;
      if (k == KIND_VOLTAGE)
         v = {s, c[13:8]};
      else
         v = {2'b00, c[12:8]};
      format_high = v;
   endfunction

   wire        rd_is_result = is_result_addr(addr);
   wire [3:0]  rd_pair      = pair_of(addr);
   wire        rd_is_high   = ~addr[0];
   wire        rd_take      = ce && reg_rd;
   wire        rd_clear     = rd_take && rd_is_result && rd_is_high;
   wire        wr_take      = ce && reg_wr;
   wire        res_take     = ce && result_we && (result_pair < PAIR_LIMIT);
   wire [6:0]  new_high     = format_high(result_kind, result_sign, result_code);
   wire [7:0]  new_low      = result_code[7:0];
   wire        fresh_at_rd  = rd_is_result ? fresh[rd_pair] : 1'b0;
   wire [7:0]  result_byte  = !rd_is_result ? REG_RESET :
                              rd_is_high ? {fresh_at_rd, res_hi[rd_pair]} : res_lo[rd_pair];
   wire [7:0]  status_low   = fresh[7:0];
   wire [7:0]  status_high  = {status_high_ctrl[7:3], conv_busy, fresh[PAIR_AMBIENT], fresh[PAIR_SUPPLY]};
   wire [DUTY_WIDTH-1:0] duty_threshold = {duty_threshold_upper, duty_ctrl[DUTY_LSB_BIT]};

   always_comb
   begin
      if (addr == ADDR_STATUS_LOW)
         read_value = status_low;
      else if (addr == ADDR_STATUS_HIGH)
         read_value = status_high;
      else if (addr == ADDR_CTRL_PAIR_LOW)
         read_value = chan_ctrl_low;
      else if (addr == ADDR_CTRL_PAIR_HIGH)
         read_value = chan_ctrl_high;
      else if (addr == ADDR_DUTY_CTRL)
         read_value = duty_ctrl;
      else if (addr == ADDR_DUTY_THRESHOLD)
         read_value = duty_threshold_upper;
      else
         read_value = result_byte;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         duty_threshold_upper <= REG_RESET;
         duty_ctrl            <= REG_RESET;
         status_high_ctrl     <= REG_RESET;
         chan_ctrl_low        <= REG_RESET;
         chan_ctrl_high       <= REG_RESET;
      end
      else if (wr_take)
      begin
         if (addr == ADDR_STATUS_HIGH)
            status_high_ctrl <= reg_wdata & STATUS_HIGH_MASK;
         else if (addr == ADDR_CTRL_PAIR_LOW)
            chan_ctrl_low <= reg_wdata;
         else if (addr == ADDR_CTRL_PAIR_HIGH)
            chan_ctrl_high <= reg_wdata;
         else if (addr == ADDR_DUTY_CTRL)
            duty_ctrl <= reg_wdata & DUTY_CTRL_MASK;
         else if (addr == ADDR_DUTY_THRESHOLD)
            duty_threshold_upper <= reg_wdata;
      end
   end

   // A result arriving in the same cycle as the read that would clear its flag keeps the flag set.
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         fresh <= '0;
         for (int i = 0; i < RESULT_PAIRS; i++)
         begin
            res_hi[i] <= 7'h00;
            res_lo[i] <= REG_RESET;
         end
      end
      else if (ce)
      begin
         for (int i = 0; i < RESULT_PAIRS; i++)
         begin
            if (res_take && (result_pair == 4'(i)))
            begin
               fresh[i]  <= 1'b1;
               res_hi[i] <= new_high;
               res_lo[i] <= new_low;
            end
            else if (rd_clear && (rd_pair == 4'(i)))
               fresh[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         reg_rdata  <= REG_RESET;
         reg_rvalid <= 1'b0;
      end
      else if (ce)
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= read_value;
      end
   end

   assign channel_enable = status_high_ctrl[7:3];
   assign repeat_mode    = duty_ctrl[REPEAT_BIT];

   duty_output_gen u_duty
   (
      .mclk      (mclk),
      .rst       (rst),
      .ce        (ce),
      .threshold (duty_threshold),
      .enable    (duty_ctrl[DUTY_ENABLE_BIT]),
      .invert    (duty_ctrl[DUTY_INVERT_BIT]),
      .duty_out  (duty_out)
   );

   sequence s_result_write;
      res_take;
   endsequence

   sequence s_high_read;
      rd_clear && !(res_take && (result_pair == rd_pair));
   endsequence

   sequence s_supply_read;
      rd_take && (addr == ADDR_SUPPLY_HIGH);
   endsequence

   sequence s_ambient_read;
      rd_take && (addr == ADDR_AMBIENT_LOW);
   endsequence

   property p_fresh_set;
      @(posedge mclk) disable iff (rst)
      s_result_write |=> fresh[$past(result_pair)];
   endproperty
   a_fresh_set: assert property (p_fresh_set) else $error("Fresh flag not set by new result.");

   property p_fresh_clear;
      @(posedge mclk) disable iff (rst)
      s_high_read |=> !fresh[$past(rd_pair)];
   endproperty
   a_fresh_clear: assert property (p_fresh_clear) else $error("Fresh flag not cleared by high-byte read.");

   property p_read_reports_flag;
      @(posedge mclk) disable iff (rst)
      rd_clear |=> reg_rvalid && (reg_rdata[FRESH_BIT] == $past(fresh_at_rd));
   endproperty
   a_read_reports_flag: assert property (p_read_reports_flag) else $error("High byte read lost flag.");

   property p_voltage_layout;
      @(posedge mclk) disable iff (rst)
      (res_take && result_kind == KIND_VOLTAGE) |=>
         (res_hi[$past(result_pair)] == {$past(result_sign), $past(result_code[13:8])}) &&
         (res_lo[$past(result_pair)] == $past(result_code[7:0]));
   endproperty
   a_voltage_layout: assert property (p_voltage_layout) else $error("Voltage result misplaced.");

   property p_temperature_layout;
      @(posedge mclk) disable iff (rst)
      (res_take && result_kind == KIND_TEMPERATURE) |=>
         (res_hi[$past(result_pair)] == {2'b00, $past(result_code[12:8])}) &&
         (res_lo[$past(result_pair)] == $past(result_code[7:0]));
   endproperty
   a_temperature_layout: assert property (p_temperature_layout) else $error("Temperature result misplaced.");

   property p_diode_layout;
      @(posedge mclk) disable iff (rst)
      (res_take && result_kind == KIND_DIODE) |=> res_hi[$past(result_pair)][SIGN_BIT:5] == 2'b00;
   endproperty
   a_diode_layout: assert property (p_diode_layout) else $error("Diode unused bits not zero.");

   property p_supply_address;
      @(posedge mclk) disable iff (rst)
      s_supply_read |=> reg_rdata == {$past(fresh[PAIR_SUPPLY]), $past(res_hi[PAIR_SUPPLY])};
   endproperty
   a_supply_address: assert property (p_supply_address) else $error("Supply high byte wrong address.");

   property p_ambient_address;
      @(posedge mclk) disable iff (rst)
      s_ambient_read |=> reg_rdata == $past(res_lo[PAIR_AMBIENT]);
   endproperty
   a_ambient_address: assert property (p_ambient_address) else $error("Ambient low byte wrong address.");

   property p_threshold_write;
      @(posedge mclk) disable iff (rst)
      (wr_take && addr == ADDR_DUTY_THRESHOLD) |=> duty_threshold[8:1] == $past(reg_wdata);
   endproperty
   a_threshold_write: assert property (p_threshold_write) else $error("Threshold upper bits not stored.");

   property p_reset_zero;
      @(posedge mclk)
      rst |=> (duty_threshold_upper == REG_RESET) && (duty_ctrl == REG_RESET) && (fresh == '0);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("Registers not zero after reset.");

   // Set beats clear so that a result landing under a read of its own high byte is never lost.
   property p_set_wins;
      @(posedge mclk) disable iff (rst)
      (res_take && rd_clear && (result_pair == rd_pair)) |=> fresh[$past(rd_pair)];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("Read clear beat a new result.");

   property p_status_keeps_flags;
      @(posedge mclk) disable iff (rst)
      (rd_take && ((addr == ADDR_STATUS_LOW) || (addr == ADDR_STATUS_HIGH)) && !res_take) |=> fresh == $past(fresh);
   endproperty
   a_status_keeps_flags: assert property (p_status_keeps_flags) else $error("Status read changed flags.");

   property p_duty_lsb_write;
      @(posedge mclk) disable iff (rst)
      (wr_take && addr == ADDR_DUTY_CTRL) |=> duty_threshold[0] == $past(reg_wdata[DUTY_LSB_BIT]);
   endproperty
   a_duty_lsb_write: assert property (p_duty_lsb_write) else $error("Threshold low bit not stored.");

   property p_duty_ctrl_write;
      @(posedge mclk) disable iff (rst)
      (wr_take && addr == ADDR_DUTY_CTRL) |=>
         duty_ctrl[DUTY_INVERT_BIT:DUTY_ENABLE_BIT] == $past(reg_wdata[DUTY_INVERT_BIT:DUTY_ENABLE_BIT]);
   endproperty
   a_duty_ctrl_write: assert property (p_duty_ctrl_write) else $error("Duty invert or enable not stored.");

   property p_flags_frozen;
      @(posedge mclk) disable iff (rst)
      !ce |=> $stable(fresh);
   endproperty
   a_flags_frozen: assert property (p_flags_frozen) else $error("Fresh flags moved while disabled.");

endmodule
`default_nettype wire

/* File: sim/reg_host_model.sv */
// Register-bus controller model that issues single-cycle read and write strobes.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
(
   input  wire logic       mclk,
   output logic [7:0]      reg_addr,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial
   begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end

   // Released lines show the inverse of their last value, so a stale sample cannot pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask

   // Data is taken only while the valid pulse stands, otherwise its inverse is returned.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      d        = (reg_rvalid === 1'b1) ? reg_rdata : ~reg_rdata;
      reg_rd   = 1'b0;
      reg_addr = ~a;
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_monitor_result_registers.sv */
// Self-checking testbench of the monitor register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_result_registers;
   import monitor_regs_pkg::*;
   logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, result_we = 1'b0, result_sign = 1'b0, conv_busy = 1'b0;
   logic [3:0] result_pair = 4'h0;
   logic [13:0] result_code = 14'h0000;
   result_kind_t result_kind = KIND_VOLTAGE;
   wire logic [7:0] reg_addr, reg_wdata, reg_rdata, chan_ctrl_low, chan_ctrl_high;
   wire logic reg_wr, reg_rd, reg_rvalid, repeat_mode, duty_out;
   wire logic [4:0] channel_enable;
   int n_fail = 0, num_checks = 0;
   logic [7:0] d, w, en;
   logic [9:0] fresh, cnt;
   logic [8:0] t;
   logic [3:0] p;
   logic [13:0] c;
   logic s;
   result_kind_t k;

   always #20 mclk = ~mclk;

   reg_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   monitor_result_registers uut (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .result_we(result_we), .result_pair(result_pair), .result_kind(result_kind),
      .result_sign(result_sign), .result_code(result_code), .conv_busy(conv_busy),
      .channel_enable(channel_enable), .chan_ctrl_low(chan_ctrl_low), .chan_ctrl_high(chan_ctrl_high),
      .repeat_mode(repeat_mode), .duty_out(duty_out));

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Voltage keeps a sign and 14 code bits; the other kinds keep 13 bits under two unused zeros.
   function automatic logic [7:0] exp_high(input result_kind_t k, input logic s, input logic [13:0] c);
      return (k == KIND_VOLTAGE) ? {1'b1, s, c[13:8]} : {3'b100, c[12:8]};
   endfunction

   task automatic put(input logic [3:0] p, input result_kind_t k, input logic s, input logic [13:0] c);
      @(negedge mclk);
      result_we   = 1'b1;
      result_pair = p;
      result_kind = k;
      result_sign = s;
      result_code = c;
      @(negedge mclk);
      result_we   = 1'b0;
      result_code = ~c;
   endtask

   initial
   begin
      #(40 * 60000);
      n_fail++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'h6b104307));
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      for (int a = 0; a < 32; a++)
      begin
         host.rd(a[7:0], d);
         chk_byte(d, REG_RESET);
      end
      w = 8'($urandom);
      host.wr(8'h06, w);
      chk_byte(chan_ctrl_low, w);
      w = 8'($urandom);
      host.wr(8'h07, w);
      chk_byte(chan_ctrl_high, w);
      en = 8'($urandom);
      host.wr(8'(ADDR_STATUS_HIGH), en);
      chk_byte({3'b000, channel_enable}, {3'b000, en[7:3]});
      for (int i = 0; i < 9; i++)
      begin
         t = (i == 0) ? 9'h001 : (i == 1) ? 9'h100 : (i == 2) ? 9'h1ff : 9'($urandom);
         w = {t[0], 2'b01, 5'($urandom)};
         host.wr(8'(ADDR_DUTY_THRESHOLD), t[8:1]);
         host.wr(8'(ADDR_DUTY_CTRL), w);
         host.rd(8'(ADDR_DUTY_THRESHOLD), d);
         chk_byte(d, t[8:1]);
         host.rd(8'(ADDR_DUTY_CTRL), d);
         chk_byte(d, w & DUTY_CTRL_MASK);
         chk_byte({7'h00, repeat_mode}, {7'h00, w[4]});
         cnt = 10'h000;
         repeat (512)
         begin
            @(negedge mclk);
            cnt = cnt + {9'h000, duty_out};
         end
         chk_cnt(cnt, {1'b0, t});
      end
      // With the clock enable low a write must leave the threshold untouched.
      ce = 1'b0;
      host.wr(8'(ADDR_DUTY_THRESHOLD), ~t[8:1]);
      ce = 1'b1;
      host.rd(8'(ADDR_DUTY_THRESHOLD), d);
      chk_byte(d, t[8:1]);
      for (int inv = 0; inv < 2; inv++)
      begin
         host.wr(8'(ADDR_DUTY_CTRL), {1'b1, inv[0], 6'h00});
         repeat (3) @(negedge mclk);
         chk_byte({7'h00, duty_out}, {7'h00, inv[0]});
      end
      fresh = 10'h000;
      for (int i = 0; i < 21; i++)
      begin
         p = (i < 20) ? 4'(i % 10) : PAIR_LIMIT;
         k = (i % 3 == 0) ? KIND_VOLTAGE : (i % 3 == 1) ? KIND_TEMPERATURE : KIND_DIODE;
         s = (i == 0) ? 1'b1 : 1'($urandom);
         c = (i == 0) ? 14'h3c29 : (i == 1) ? 14'h1d80 : 14'($urandom);
         conv_busy = 1'($urandom);
         put(p, k, s, c);
         if (p < PAIR_LIMIT)
            fresh[p] = 1'b1;
         host.rd(8'(ADDR_STATUS_LOW), d);
         chk_byte(d, fresh[7:0]);
         host.rd(8'(ADDR_STATUS_HIGH), d);
         chk_byte(d, {en[7:3], conv_busy, fresh[8], fresh[9]});
         if (p < PAIR_LIMIT)
         begin
            host.rd(8'(ADDR_RESULT_FIRST + {p, 1'b0}), d);
            chk_byte(d, exp_high(k, s, c));
            host.rd(8'(ADDR_RESULT_FIRST + {p, 1'b1}), d);
            chk_byte(d, c[7:0]);
            host.rd(8'(ADDR_RESULT_FIRST + {p, 1'b0}), d);
            chk_byte(d, exp_high(k, s, c) & 8'h7f);
            fresh[p] = 1'b0;
         end
      end
      fork
         put(4'h9, KIND_VOLTAGE, 1'b0, 14'h028f);
         host.rd(8'(ADDR_SUPPLY_HIGH), d);
      join
      host.rd(8'(ADDR_STATUS_HIGH), d);
      chk_byte(d, {en[7:3], conv_busy, 2'b01});
      host.rd(8'(ADDR_SUPPLY_HIGH), d);
      chk_byte(d, exp_high(KIND_VOLTAGE, 1'b0, 14'h028f));
      finish_test();
   end
endmodule
`default_nettype wire
